// File: hw/cdce_top.sv
// Configuration completion line and chain enable sequencer
//
// Behaviour
// [R1] Hold completion line low until load done
// [R2] Release completion line on error-free load
// [R3] Ignore completion line low in user mode
// [R4] Others never pull completion line early
// [R5] Initialise only after completion line reads high
// [R6] Accept configuration only while enable is low
// [R7] Enable held low through all phases
// [R8] Single device ties enable low
// [R9] Chain output feeds next device enable
// [R10] Enable held low for boundary-scan programming
// [R11] Drive chain output low when configured
// [R12] Pull error line low on load error
// [R13] Request low resets; rising edge reloads
// [R14] Chain output high until configured
`timescale 1ns/100ps
module cdce_top
   import cdce_pkg::*;
#(
   parameter int INIT_CYCLES = cdce_pkg::CDCE_INIT_CYCLES
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic config_request_n,
   input wire logic chip_enable_n,
   input wire logic load_done,
   input wire logic load_error,
   input wire logic config_complete_line_in,
   output logic config_complete_line_out,
   output logic config_complete_line_oe,
   input wire logic error_status_line_n_in,
   output logic error_status_line_n_out,
   output logic error_status_line_n_oe,
   output logic chain_enable_out_n,
   output logic config_enable,
   output logic user_mode,
   output logic user_pins_float
);
   import cdce_pkg::*;

   // ==========================================
   // Pin synchronisers
   logic [3:0] pins_raw;
   logic [3:0] pins_sync;
   logic req_n_s;
   logic ce_n_s;
   logic done_s;
   logic stat_s;
   logic req_n_d;

   assign pins_raw = {config_request_n, chip_enable_n,
                      config_complete_line_in, error_status_line_n_in};

   cdce_sync #(.WIDTH(4), .RST_VAL(CDCE_SYNC_RST)) u_sync (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .din(pins_raw),
      .dout(pins_sync)
   );

   assign req_n_s = pins_sync[3];
   assign ce_n_s = pins_sync[2];
   assign done_s = pins_sync[1];
   assign stat_s = pins_sync[0];

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         req_n_d <= 1'b1;
      end else begin
         req_n_d <= req_n_s;
      end
   end

   // ==========================================
   // Sequencer
   cdce_state_t state;
   cdce_state_t next_state;
   logic [CDCE_CNT_W-1:0] init_cnt;
   logic init_last;
   logic req_rise;

   assign req_rise = req_n_s && !req_n_d; // [R13]
   assign init_last = (init_cnt == CDCE_CNT_W'(INIT_CYCLES - 1));

   always_comb begin
      next_state = state;
      case (state)
         CDCE_RESET: begin
            if (req_rise) begin
               next_state = CDCE_LOAD; // [R13]
            end
         end
         CDCE_LOAD: begin
            // Enable high simply stalls the load
            if (!ce_n_s && load_error) begin
               next_state = CDCE_ERROR; // [R12]
            end else if (!ce_n_s && load_done) begin
               next_state = CDCE_WAIT_HI; // [R6]
            end
         end
         CDCE_WAIT_HI: begin
            // External low before user mode is a fault
            if (!stat_s) begin
               next_state = CDCE_ERROR;
            end else if (done_s) begin
               next_state = CDCE_INIT; // [R5]
            end
         end
         CDCE_INIT: begin
            if (!stat_s || !done_s) begin
               next_state = CDCE_ERROR;
            end else if (init_last) begin
               next_state = CDCE_USER; // [R5]
            end
         end
         CDCE_USER: begin
            next_state = CDCE_USER; // [R3]
         end
         CDCE_ERROR: begin
            next_state = CDCE_ERROR;
         end
         default: begin
            next_state = CDCE_RESET;
         end
      endcase
      // Request low overrides every state
      if (!req_n_s) begin
         next_state = CDCE_RESET; // [R13]
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= CDCE_RESET;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         init_cnt <= '0;
      end else if (state == CDCE_INIT) begin
         init_cnt <= init_cnt + CDCE_CNT_W'(1);
      end else begin
         init_cnt <= '0;
      end
   end

   // ==========================================
   // Open-drain lines, chain output, status
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         config_complete_line_oe <= CDCE_RST_DRIVE_LOW;
      end else begin
         config_complete_line_oe <= (next_state == CDCE_RESET) ||
                                    (next_state == CDCE_LOAD) ||
                                    (next_state == CDCE_ERROR); // [R1] [R2]
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         error_status_line_n_oe <= 1'b0;
      end else begin
         error_status_line_n_oe <= (next_state == CDCE_ERROR); // [R12]
      end
   end

   // Open-drain: data is always low, oe decides
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         config_complete_line_out <= 1'b0;
         error_status_line_n_out <= 1'b0;
      end else begin
         config_complete_line_out <= 1'b0;
         error_status_line_n_out <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         chain_enable_out_n <= CDCE_RST_CHAIN_N; // [R14]
      end else begin
         chain_enable_out_n <= !((next_state == CDCE_INIT) ||
                                 (next_state == CDCE_USER)); // [R11] [R9]
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         config_enable <= 1'b0;
         user_mode <= 1'b0;
         user_pins_float <= 1'b1;
      end else begin
         config_enable <= (next_state == CDCE_LOAD) && !ce_n_s; // [R6]
         user_mode <= (next_state == CDCE_USER);
         user_pins_float <= (next_state != CDCE_USER); // [R13]
      end
   end
endmodule

// File: common/cdce_pkg.sv
// Package for the configuration completion and chain enable block
package cdce_pkg;
   // ==========================================
   // Sequencer states
   typedef enum logic [5:0] {
      CDCE_RESET    = 6'h01,
      CDCE_LOAD     = 6'h02,
      CDCE_WAIT_HI  = 6'h04,
      CDCE_INIT     = 6'h08,
      CDCE_USER     = 6'h10,
      CDCE_ERROR    = 6'h20
   } cdce_state_t;

   // ==========================================
   // Counts and reset values
   localparam int CDCE_INIT_CYCLES = 16;
   localparam int CDCE_CNT_W = 16;
   localparam logic CDCE_RST_DRIVE_LOW = 1'b1;
   localparam logic CDCE_RST_CHAIN_N = 1'b1;
   // Pins idle high, so no false request edge after reset
   localparam logic [3:0] CDCE_SYNC_RST = 4'hF;
endpackage

// File: hw/cdce_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module cdce_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '1
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage1;

   // First stage feeds only the second
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1 <= RST_VAL;
         dout <= RST_VAL;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule

// File: dv/cdce_partner.sv
// Open-drain wire with pull-up, as the far side sees it
`timescale 1ns/100ps
module cdce_partner(
   input wire logic dev_oe,
   input wire logic ext_low,
   output logic line
);
   // Pull-up wins only when nobody pulls low
   assign line = !(dev_oe || ext_low);
endmodule

// File: dv/cdce_top_chk.sv
// Checker for the completion and chain enable block
`timescale 1ns/100ps
module cdce_top_chk(
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic config_request_n,
   input wire logic chip_enable_n,
   input wire logic load_done,
   input wire logic load_error,
   input wire logic config_complete_line_in,
   input wire logic config_complete_line_oe,
   input wire logic error_status_line_n_oe,
   input wire logic config_complete_line_out,
   input wire logic error_status_line_n_out,
   input wire logic chain_enable_out_n,
   input wire logic config_enable,
   input wire logic user_mode,
   input wire logic user_pins_float
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   property p_hold;
      $fell(config_complete_line_oe) |-> $past(load_done && config_enable);
   endproperty
   property p_rel;
      load_done && config_enable |=> !config_complete_line_oe;
   endproperty
   property p_ce;
      chip_enable_n [*4] |-> !config_enable;
   endproperty
   property p_chain;
      !chain_enable_out_n |-> !config_complete_line_oe;
   endproperty
   property p_init;
      $fell(chain_enable_out_n) |-> $past(config_complete_line_in, 2);
   endproperty
   property p_user;
      (user_mode && config_request_n) [*4] |=> user_mode;
   endproperty
   property p_err;
      load_error && config_enable |=> error_status_line_n_oe;
   endproperty
   property p_req;
      !config_request_n [*5] |-> user_pins_float && chain_enable_out_n;
   endproperty
   property p_busy;
      config_enable |-> chain_enable_out_n;
   endproperty
   property p_odrain;
      !config_complete_line_out && !error_status_line_n_out;
   endproperty
   a_hold: assert property (p_hold) else $error("early release");
   a_rel: assert property (p_rel) else $error("no release");
   a_ce: assert property (p_ce) else $error("load while off");
   a_chain: assert property (p_chain) else $error("chain early");
   a_init: assert property (p_init) else $error("init early");
   a_user: assert property (p_user) else $error("user lost");
   a_err: assert property (p_err) else $error("no error pull");
   a_req: assert property (p_req) else $error("no clear");
   a_busy: assert property (p_busy) else $error("chain low");
   a_odrain: assert property (p_odrain) else $error("line driven high");
   c_user: cover property ($rose(user_mode));
   c_err: cover property ($rose(error_status_line_n_oe));
   c_off: cover property (chip_enable_n && load_done);
   c_chain: cover property ($fell(chain_enable_out_n));
endmodule
bind cdce_top cdce_top_chk i_chk(.*);

// File: dv/tb_cdce_top.sv
// Testbench for the completion and chain enable block
`timescale 1ns/100ps
module tb_cdce_top;
   // Enable low from the start, as for a lone or first device
   logic core_clk = 0, arst_n = 0, req_n = 0, ce_n = 0;
   logic done = 0, err = 0, cd_low = 0, st_low = 0;
   logic cd_oe, st_oe, cd_w, st_w, ceo_n, cfg_en, um, flt;
   int mismatches = 0, samples_checked = 0;
   initial forever #20 core_clk = ~core_clk;
   cdce_partner i_cd(.dev_oe(cd_oe), .ext_low(cd_low), .line(cd_w));
   cdce_partner i_st(.dev_oe(st_oe), .ext_low(st_low), .line(st_w));
   cdce_top #(.INIT_CYCLES(2)) i_dut(.core_clk(core_clk), .arst_n(arst_n),
      .config_request_n(req_n), .chip_enable_n(ce_n), .load_done(done),
      .load_error(err), .config_complete_line_in(cd_w),
      .config_complete_line_out(), .config_complete_line_oe(cd_oe),
      .error_status_line_n_in(st_w), .error_status_line_n_out(),
      .error_status_line_n_oe(st_oe), .chain_enable_out_n(ceo_n),
      .config_enable(cfg_en), .user_mode(um), .user_pins_float(flt));
   task automatic chk(logic seen, logic exp);
      #1;
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t saw %b want %b", $time, seen, exp);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge core_clk);
   endtask
   // Low then high: a rising edge is what starts a load
   task automatic restart();
      cyc(1);
      req_n <= 0;
      cyc(4);
      req_n <= 1;
      cyc(5);
   endtask
   task automatic pulse(logic e);
      cyc(1);
      done <= !e;
      err <= e;
      cyc(1);
      done <= 0;
      err <= 0;
      cyc(2);
   endtask
   task automatic t_stall();
      cyc(1);
      ce_n <= 1;
      restart();
      pulse(0);
      chk(cfg_en, 0);
      chk(cd_oe, 1);
      cyc(1);
      ce_n <= 0;
      cyc(4);
      chk(cfg_en, 1);
   endtask
   task automatic t_load();
      pulse(0);
      chk(cd_oe, 0);
      for (int i = 0; i < 20 && um !== 1; i++) cyc(1);
      chk(um, 1);
      chk(ceo_n, 0);
      chk(flt, 0);
      cyc(1);
      cd_low <= 1;
      cyc(6);
      chk(um, 1);
      cyc(1);
      cd_low <= 0;
   endtask
   task automatic t_err();
      restart();
      chk(um, 0);
      pulse(1);
      chk(st_oe, 1);
      chk(cd_oe, 1);
      chk(ceo_n, 1);
      cyc(1);
      req_n <= 0;
      cyc(5);
      chk(flt, 1);
      chk(st_oe, 0);
   endtask
   // Neighbour pulls error line low while waiting for release
   task automatic t_ext();
      restart();
      cyc(1);
      st_low <= 1;
      pulse(0);
      chk(cd_oe, 1);
      chk(st_oe, 1);
      chk(ceo_n, 1);
      chk(um, 0);
      cyc(1);
      st_low <= 0;
      req_n <= 0;
      cyc(5);
      chk(st_oe, 0);
      chk(flt, 1);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      cyc(6);
      arst_n <= 1;
      cyc(1);
      chk(cd_oe, 1);
      chk(ceo_n, 1);
      t_stall();
      t_load();
      t_err();
      t_ext();
      tally_and_finish();
   end
   initial begin
      #100000;
      mismatches++;
      tally_and_finish();
   end
endmodule
